// file: hdl/watch_timer_pkg.sv
/*
  shared constants and types of the watch and interval timer:
  register map, mode register layout, interrupt bits, divider figures.
  assumes a 32-bit AHB-Lite register bus with word-aligned registers.
*/
package watch_timer_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [31:0] MODE_ADDR = 32'h0000ff9c;
  localparam logic [31:0] STATUS_ADDR = 32'h0000ffa0;
  localparam logic [31:0] MASK_ADDR = 32'h0000ffa4;
  localparam logic [31:0] MODE_SET_ADDR = 32'h0000ffa8;
  localparam logic [31:0] MODE_CLR_ADDR = 32'h0000ffac;

  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] MODE_WRITABLE = 8'hfb; // bit 2 is reserved
  localparam logic [1:0] IRQ_RESET = 2'h0;

  // interrupt status and mask bit positions
  localparam int IRQ_WATCH_BIT = 0;
  localparam int IRQ_INTERVAL_BIT = 1;
  localparam int IRQ_BITS = 2;

  // ----------------------------------------------------------------
  // timing figures
  // ----------------------------------------------------------------
  localparam int MAIN_DIV_LOG2 = 7;      // main clock divided by 2^7
  localparam int PRESCALER_WIDTH = 9;
  localparam int COUNTER_WIDTH = 5;
  localparam int INTERVAL_BASE_TAP = 4;  // code 0 selects 2^4
  localparam logic [2:0] INTERVAL_LAST_CODE = 3'h5;
  localparam int SHORT_WATCH_TAP = 5;    // 2^5 fw watch period

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // mode control register layout
  typedef struct packed {
    logic clock_source_select;
    logic [2:0] interval_select;  // hi, mid, lo
    logic watch_flag_period_select;
    logic reserved;
    logic counter_run;
    logic block_enable;
  } mode_t;

endpackage

// file: hdl/watch_prescaler.sv
/*
  ripple-free binary prescaler driven by a one-cycle count tick.
  tap[i] pulses once every 2^i ticks, one clock after the tick.
  assumes tick is a single-cycle pulse on CLK.
*/
`timescale 1ns/1ns
module watch_prescaler #(
  parameter int WIDTH = 9
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clear,
  input wire logic tick,
  output logic [WIDTH-1:0] count,
  output logic [WIDTH:1] tap
);

  logic [WIDTH-1:0] cnt_q;
  logic [WIDTH:1] tap_q;

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  // clear wins over a tick so a stopped block always restarts at zero
  always_ff @(posedge clk) begin
    if (!reset_n || clear) begin
      cnt_q <= '0;
    end else if (tick) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // stage outputs, one per power of two
  // ----------------------------------------------------------------
  for (genvar i = 1; i <= WIDTH; i++) begin : g_tap
    always_ff @(posedge clk) begin
      if (!reset_n || clear) begin
        tap_q[i] <= 1'b0;
      end else begin
        tap_q[i] <= tick && (&cnt_q[i-1:0]);
      end
    end
  end

  assign count = cnt_q;
  assign tap = tap_q;

endmodule // watch_prescaler

// file: hdl/watch_and_interval_timer.sv
/*
  watch timer with interval timer: count clock select, shared 9-bit
  prescaler, 5-bit watch counter, ahb-lite register slave, interrupts.
  assumes SUB_CLK is a slow asynchronous clock well below CLK/4 and
  a single ahb-lite master with no wait states inserted upstream.
*/
`timescale 1ns/1ns

// Operation
// - clock_source_select: 0 takes main clock over 2^7, 1 takes subsystem clock
// - interval_select codes 0..5 give 2^4..2^9 fw; other codes prohibited
// - while enabled the interval interrupt repeats every selected interval
// - watch_flag_period_select: 0 gives 2^14 fw, 1 gives 2^5 fw
// - counter_run 1 starts the 5-bit counter, 0 stops and clears it
// - block_enable 0 stops and clears prescaler and counter; 1 enables
// - watch counting needs both enable and run; clearing clears the counter
// - clearing only counter_run restarts the watch, prescaler keeps running
// - counter counts one cycle after prescaler output; later periods exact
// - reset loads the mode register with zero, block stopped
// - mode register takes single-bit set/clear as well as whole writes
// - watch interrupt period is 2^14 fw (0.5 s at 32.768 kHz), or 2^5 fw when selected
// - watch and interval functions run together from one prescaler
module watch_and_interval_timer (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic SUB_CLK,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  output logic WATCH_TICK_IRQ,
  output logic INTERVAL_IRQ,
  output logic IRQ
);

  localparam int PW = watch_timer_pkg::PRESCALER_WIDTH;
  localparam int CW = watch_timer_pkg::COUNTER_WIDTH;
  localparam int DW = watch_timer_pkg::MAIN_DIV_LOG2;
  localparam int NI = watch_timer_pkg::IRQ_BITS;

  watch_timer_pkg::mode_t mode_q;
  logic [NI-1:0] status_q;
  logic [NI-1:0] mask_q;
  logic [31:0] hrdata_q;
  logic hreadyout_q, hresp_q, wr_pend_q;
  logic [31:0] wr_addr_q;
  logic [DW-1:0] div_q;
  logic sub_s1_q, sub_s2_q, sub_s3_q, fw_tick_q;
  logic [PW-1:0] presc_count;
  logic [PW:1] tap;
  logic [CW-1:0] cnt_q;
  logic stage_d_q, watch_q, interval_q, irq_q;
  logic watch_run, watch_hit, interval_hit, addr_phase;
  logic [7:0] mode_wdata;
  logic [31:0] rd_mux;

  // ----------------------------------------------------------------
  // ahb-lite slave
  // ----------------------------------------------------------------
  assign addr_phase = HSEL && HREADY && (HTRANS == watch_timer_pkg::HTRANS_NONSEQ);
  assign mode_wdata = HWDATA[7:0] & watch_timer_pkg::MODE_WRITABLE;

  // zero wait states; the response is always okay
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      hreadyout_q <= 1'b0;
      hresp_q <= 1'b0;
    end else begin
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end
  end

  // write address is held for the data phase that follows
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
    end else begin
      wr_pend_q <= addr_phase && HWRITE;
      wr_addr_q <= HADDR;
    end
  end

  // read mux; unmapped addresses read as zero
  always_comb begin
    rd_mux = '0;
    case (HADDR)
      watch_timer_pkg::MODE_ADDR: rd_mux = {24'h000000, mode_q};
      watch_timer_pkg::STATUS_ADDR: rd_mux = {30'h00000000, status_q};
      watch_timer_pkg::MASK_ADDR: rd_mux = {30'h00000000, mask_q};
      default: rd_mux = '0;
    endcase
  end

  // read data is captured at the address phase so it stands in the data phase
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      hrdata_q <= '0;
    end else if (addr_phase && !HWRITE) begin
      hrdata_q <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // mode control register
  // ----------------------------------------------------------------
  // the set/clear aliases give bit-level manipulation without read-modify-write
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      mode_q <= watch_timer_pkg::MODE_RESET;
    end else if (wr_pend_q) begin
      case (wr_addr_q)
        watch_timer_pkg::MODE_ADDR: mode_q <= mode_wdata;
        watch_timer_pkg::MODE_SET_ADDR: mode_q <= mode_q | mode_wdata;
        watch_timer_pkg::MODE_CLR_ADDR: mode_q <= mode_q & ~mode_wdata;
        default: mode_q <= mode_q;
      endcase
    end
  end

  // interrupt mask
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      mask_q <= watch_timer_pkg::IRQ_RESET;
    end else if (wr_pend_q && wr_addr_q == watch_timer_pkg::MASK_ADDR) begin
      mask_q <= HWDATA[NI-1:0];
    end
  end

  // ----------------------------------------------------------------
  // count clock select
  // ----------------------------------------------------------------
  // subsystem clock synchroniser; edge found between second and third stage
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      sub_s1_q <= 1'b0;
      sub_s2_q <= 1'b0;
      sub_s3_q <= 1'b0;
    end else begin
      sub_s1_q <= SUB_CLK;
      sub_s2_q <= sub_s1_q;
      sub_s3_q <= sub_s2_q;
    end
  end

  // main clock divider runs freely; its phase is not tied to enable
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  // fw tick: one clock pulse per watch count clock period
  always_ff @(posedge CLK) begin
    if (!RESET_N || !mode_q.block_enable) begin
      fw_tick_q <= 1'b0;
    end else if (mode_q.clock_source_select) begin
      fw_tick_q <= sub_s2_q && !sub_s3_q;
    end else begin
      fw_tick_q <= &div_q;
    end
  end

  // ----------------------------------------------------------------
  // shared prescaler
  // ----------------------------------------------------------------
  // only block_enable clears it, so counter_run alone leaves it running
  watch_prescaler #(
    .WIDTH(PW)
  ) u_prescaler (
    .clk(CLK),
    .reset_n(RESET_N),
    .clear(!mode_q.block_enable),
    .tick(fw_tick_q),
    .count(presc_count),
    .tap(tap)
  );

  // ----------------------------------------------------------------
  // watch counter
  // ----------------------------------------------------------------
  assign watch_run = mode_q.block_enable && mode_q.counter_run;

  // the counter sees the prescaler output one cycle late
  always_ff @(posedge CLK) begin
    if (!RESET_N || !mode_q.block_enable) begin
      stage_d_q <= 1'b0;
    end else begin
      stage_d_q <= tap[PW];
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N || !watch_run) begin
      cnt_q <= '0;
    end else if (stage_d_q) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // long period on counter wrap, short period straight from the 2^5 stage
  always_comb begin
    if (!watch_run) begin
      watch_hit = 1'b0;
    end else if (mode_q.watch_flag_period_select) begin
      watch_hit = tap[watch_timer_pkg::SHORT_WATCH_TAP];
    end else begin
      watch_hit = stage_d_q && (&cnt_q);
    end
  end

  // ----------------------------------------------------------------
  // interval function
  // ----------------------------------------------------------------
  // prohibited codes simply never fire
  always_comb begin
    interval_hit = 1'b0;
    if (mode_q.block_enable && mode_q.interval_select <= watch_timer_pkg::INTERVAL_LAST_CODE) begin
      interval_hit = tap[watch_timer_pkg::INTERVAL_BASE_TAP + int'(mode_q.interval_select)];
    end
  end

  // ----------------------------------------------------------------
  // interrupt outputs
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      watch_q <= 1'b0;
      interval_q <= 1'b0;
    end else begin
      watch_q <= watch_hit;
      interval_q <= interval_hit;
    end
  end

  // sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      status_q <= watch_timer_pkg::IRQ_RESET;
    end else begin
      for (int b = 0; b < NI; b++) begin
        if ((b == watch_timer_pkg::IRQ_WATCH_BIT && watch_hit) ||
            (b == watch_timer_pkg::IRQ_INTERVAL_BIT && interval_hit)) begin
          status_q[b] <= 1'b1;
        end else if (wr_pend_q && wr_addr_q == watch_timer_pkg::STATUS_ADDR && HWDATA[b]) begin
          status_q[b] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_q & mask_q);
    end
  end

  assign HRDATA = hrdata_q;
  assign HREADYOUT = hreadyout_q;
  assign HRESP = hresp_q;
  assign WATCH_TICK_IRQ = watch_q;
  assign INTERVAL_IRQ = interval_q;
  assign IRQ = irq_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_long_wrap;
    watch_run && !mode_q.watch_flag_period_select && stage_d_q && (&cnt_q);
  endsequence
  sequence s_watch_pulse;
    WATCH_TICK_IRQ && cnt_q == '0;
  endsequence
  property p_reset_mode;
    @(posedge CLK) !RESET_N |=> mode_q == watch_timer_pkg::MODE_RESET;
  endproperty
  a_reset_mode: assert property (p_reset_mode) else $error("mode not cleared by reset");
  property p_reserved_zero;
    @(posedge CLK) disable iff (!RESET_N) wr_pend_q |=> !mode_q.reserved;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved mode bit set");
  property p_disable_clears;
    @(posedge CLK) disable iff (!RESET_N) !mode_q.block_enable |=> presc_count == '0 && cnt_q == '0;
  endproperty
  a_disable_clears: assert property (p_disable_clears) else $error("stop did not clear");
  property p_run_clears;
    @(posedge CLK) disable iff (!RESET_N) mode_q.block_enable && !mode_q.counter_run |=> cnt_q == '0;
  endproperty
  a_run_clears: assert property (p_run_clears) else $error("counter not cleared");
  property p_presc_keeps_running;
    @(posedge CLK) disable iff (!RESET_N)
      mode_q.block_enable && !mode_q.counter_run && fw_tick_q ##1 mode_q.block_enable
      |-> presc_count == PW'($past(presc_count) + 1'b1);
  endproperty
  a_presc_keeps_running: assert property (p_presc_keeps_running) else $error("prescaler halted");
  property p_counter_advance;
    @(posedge CLK) disable iff (!RESET_N) watch_run && stage_d_q ##1 watch_run |-> cnt_q == CW'($past(cnt_q) + 1'b1);
  endproperty
  a_counter_advance: assert property (p_counter_advance) else $error("counter missed stage");
  property p_long_watch;
    @(posedge CLK) disable iff (!RESET_N) s_long_wrap |=> s_watch_pulse;
  endproperty
  a_long_watch: assert property (p_long_watch) else $error("missing watch irq on wrap");
  property p_short_watch;
    @(posedge CLK) disable iff (!RESET_N)
      watch_run && mode_q.watch_flag_period_select && tap[watch_timer_pkg::SHORT_WATCH_TAP] |=> WATCH_TICK_IRQ;
  endproperty
  a_short_watch: assert property (p_short_watch) else $error("missing short watch irq");
  property p_interval_fire;
    @(posedge CLK) disable iff (!RESET_N)
      mode_q.block_enable && mode_q.interval_select == 3'h0 && tap[watch_timer_pkg::INTERVAL_BASE_TAP]
      |=> INTERVAL_IRQ;
  endproperty
  a_interval_fire: assert property (p_interval_fire) else $error("missing interval irq");
  property p_main_source;
    @(posedge CLK) disable iff (!RESET_N)
      mode_q.block_enable && !mode_q.clock_source_select && fw_tick_q |-> div_q == '0;
  endproperty
  a_main_source: assert property (p_main_source) else $error("fw not main over 2^7");

endmodule // watch_and_interval_timer

// file: tb/test_watch_and_interval_timer.sv
/*
  self-checking bench of the watch and interval timer: ahb-lite register
  access, interval and watch periods counted in fw ticks, interrupts.
  assumes the design answers with zero wait states and counts SUB_CLK rises.
*/
`timescale 1ns/1ns
module test_watch_and_interval_timer;
  localparam int LIMIT = 90000;
  logic CLK = 1'b0;
  logic RESET_N = 1'b0;
  logic SUB_CLK = 1'b0;
  logic HSEL = 1'b0;
  logic [31:0] HADDR = 32'h0;
  logic [1:0] HTRANS = 2'h0;
  logic HWRITE = 1'b0;
  logic [31:0] HWDATA = 32'h0;
  logic [31:0] HRDATA;
  logic HREADYOUT;
  logic HRESP;
  logic WATCH_TICK_IRQ;
  logic INTERVAL_IRQ;
  logic IRQ;
  int err_total = 0;
  int checked = 0;
  int cycles = 0;
  int fw_cnt = 0;
  int sub_div = 0;
  int sub_half = 4;
  bit sub_run = 1'b0;
  logic [31:0] rng = 32'h00010144;
  logic [31:0] r;
  int t;
  int cy;
  int wi;
  int ii;
  // register model kept from the writes the bench makes
  logic [7:0] mode_m = 8'h00;
  logic [1:0] mask_m = 2'h0;
  int per_q[$];

  // single slave: its ready is the bus ready
  watch_and_interval_timer u_dut (.CLK(CLK), .RESET_N(RESET_N), .SUB_CLK(SUB_CLK), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA),
    .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .WATCH_TICK_IRQ(WATCH_TICK_IRQ), .INTERVAL_IRQ(INTERVAL_IRQ), .IRQ(IRQ));

  // ----------------------------------------------------------------
  // clocks and timeout
  // ----------------------------------------------------------------
  always #5 CLK = ~CLK;

  // sub clock period of 8 clk or more, so every rise is one fw tick
  always @(posedge CLK) begin
    cycles <= cycles + 1;
    if (!sub_run) begin
      SUB_CLK <= 1'b0;
      sub_div <= 0;
    end else if (sub_div >= sub_half - 1) begin
      SUB_CLK <= ~SUB_CLK;
      sub_div <= 0;
      if (!SUB_CLK) fw_cnt <= fw_cnt + 1;
    end else sub_div <= sub_div + 1;
  end

  always @(posedge CLK) if (cycles >= LIMIT) begin
    err_total = err_total + 1;
    conclude();
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  function automatic logic [31:0] xorshift(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // entered just after an edge; waits on ready, never on a fixed count
  task automatic bus(input bit wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= a;
    HWRITE <= wr;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    q = HRDATA;
    check({31'h0, HRESP}, 32'h0);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
    // the model follows every write; bit 2 never takes a value
    case (a)
      watch_timer_pkg::MODE_ADDR: mode_m = d[7:0] & ~8'h04;
      watch_timer_pkg::MODE_SET_ADDR: mode_m = mode_m | (d[7:0] & ~8'h04);
      watch_timer_pkg::MODE_CLR_ADDR: mode_m = mode_m & ~d[7:0];
      watch_timer_pkg::MASK_ADDR: mask_m = d[1:0];
      default: ;
    endcase
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask

  task automatic wait_pulse(input bit watch);
    do @(posedge CLK); while ((watch ? WATCH_TICK_IRQ : INTERVAL_IRQ) !== 1'b1);
  endtask

  // fw ticks and clk cycles between two successive pulses
  task automatic gap(input bit watch, output int ticks, output int cyc);
    int t0;
    int c0;
    wait_pulse(watch);
    t0 = fw_cnt;
    c0 = cycles;
    wait_pulse(watch);
    ticks = fw_cnt - t0;
    cyc = cycles - c0;
  endtask

  task automatic quiet(input int n, output int w, output int i);
    int t0;
    t0 = fw_cnt;
    w = 0;
    i = 0;
    while (fw_cnt - t0 < n) begin
      @(posedge CLK);
      w = w + (WATCH_TICK_IRQ === 1'b1);
      i = i + (INTERVAL_IRQ === 1'b1);
    end
  endtask

  task automatic conclude();
    $display("mismatches %0d, comparisons %0d", err_total, checked);
    if (err_total == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge CLK);
    RESET_N <= 1'b1;
    repeat (2) @(posedge CLK);
    rd_chk(watch_timer_pkg::MODE_ADDR, 32'h0);
    rd_chk(watch_timer_pkg::STATUS_ADDR, 32'h0);
    rd_chk(watch_timer_pkg::MASK_ADDR, 32'h0);
    rng = xorshift(rng);
    wr(32'h0000ff00, rng);
    rd_chk(32'h0000ff00, 32'h0);
    // whole writes and multi-bit set/clear; the reserved bit never sticks
    wr(watch_timer_pkg::MODE_ADDR, 32'hff);
    rd_chk(watch_timer_pkg::MODE_ADDR, 32'hfb);
    wr(watch_timer_pkg::MODE_CLR_ADDR, 32'h0f);
    rd_chk(watch_timer_pkg::MODE_ADDR, 32'hf0);
    wr(watch_timer_pkg::MODE_SET_ADDR, 32'h05);
    rd_chk(watch_timer_pkg::MODE_ADDR, 32'hf1);
    rd_chk(watch_timer_pkg::MODE_SET_ADDR, 32'h0);
    sub_run = 1'b1;
    // expected interval lengths, code 0 first
    for (int c = 0; c < 6; c++) begin
      per_q.push_back(1 << (4 + c));
    end
    // every legal interval code, stopped before each rewrite
    for (int c = 0; c < 6; c++) begin
      rng = xorshift(rng);
      sub_half = 4 + int'(rng % 3);
      wr(watch_timer_pkg::MODE_ADDR, 32'h0);
      wr(watch_timer_pkg::MODE_ADDR, 32'h81 | (c << 4));
      rd_chk(watch_timer_pkg::MODE_ADDR, {24'h0, mode_m});
      gap(1'b0, t, cy);
      check(t, per_q.pop_front());
    end
    wr(watch_timer_pkg::MODE_ADDR, 32'h0);
    wr(watch_timer_pkg::MODE_ADDR, 32'he1);
    quiet(600, wi, ii);
    check(ii, 32'h0);
    wr(watch_timer_pkg::MODE_ADDR, 32'h8a);
    quiet(100, wi, ii);
    check(wi + ii, 32'h0);
    // long watch period: 1100 ticks stay well inside one 2^14 period
    wr(watch_timer_pkg::MODE_ADDR, 32'h0);
    wr(watch_timer_pkg::MODE_ADDR, 32'h83);
    quiet(1100, wi, ii);
    check(wi, 32'h0);
    // short watch period, then counter_run cleared alone and set again
    wr(watch_timer_pkg::MODE_ADDR, 32'h0);
    wr(watch_timer_pkg::MODE_ADDR, 32'h8b);
    gap(1'b1, t, cy);
    check(t, 32'h20);
    gap(1'b1, t, cy);
    check(t, 32'h20);
    wr(watch_timer_pkg::MODE_CLR_ADDR, 32'h2);
    quiet(100, wi, ii);
    check(wi, 32'h0);
    gap(1'b0, t, cy);
    check(t, 32'h10);
    wr(watch_timer_pkg::MODE_SET_ADDR, 32'h2);
    gap(1'b1, t, cy);
    check(t, 32'h20);
    // sticky status, mask and the level interrupt
    bus(1'b0, watch_timer_pkg::STATUS_ADDR, 32'h0, r);
    check(r & 32'h3, 32'h3);
    check({31'h0, IRQ}, 32'h0);
    rng = xorshift(rng);
    wr(watch_timer_pkg::MASK_ADDR, rng);
    rd_chk(watch_timer_pkg::MASK_ADDR, rng & 32'h3);
    wr(watch_timer_pkg::MASK_ADDR, 32'h2);
    rd_chk(watch_timer_pkg::MASK_ADDR, {30'h0, mask_m});
    repeat (2) @(posedge CLK);
    check({31'h0, IRQ}, 32'h1);
    wr(watch_timer_pkg::MODE_ADDR, 32'h0);
    wr(watch_timer_pkg::STATUS_ADDR, 32'h3);
    rd_chk(watch_timer_pkg::STATUS_ADDR, 32'h0);
    repeat (2) @(posedge CLK);
    check({31'h0, IRQ}, 32'h0);
    // main clock over 128 as count clock, sub clock held still
    sub_run = 1'b0;
    wr(watch_timer_pkg::MODE_ADDR, 32'h01);
    gap(1'b0, t, cy);
    check(cy, 32'd2048);
    conclude();
  end
endmodule // test_watch_and_interval_timer
